// ---- nrw_pkg.sv ----
// ==========================================================================
// shared constants and carriers for the node reset / watchdog / link regs
// ==========================================================================
package nrw_pkg;

   // ======================================================================
   // register indices (configuration packet address space)
   // ======================================================================
   localparam logic [7:0]  IDX_RST_MODE    = 8'h50;
   localparam logic [7:0]  IDX_OSC_FREQ    = 8'h51;
   localparam logic [7:0]  IDX_LINK_CTRL   = 8'h80;
   localparam logic [7:0]  IDX_WDOG_CTRL   = 8'hd6;
   localparam logic [7:0]  IDX_WDOG_KEY    = 8'hd7;

   // ======================================================================
   // field positions
   // ======================================================================
   localparam int          RM_SYS_BIT      = 0;
   localparam int          RM_TILE_BIT     = 1;
   localparam int          RM_MODE_LSB     = 16;
   localparam int          RM_TRI_BIT      = 24;
   localparam int          LK_ERR_BIT      = 27;
   localparam int          LK_GREET_BIT    = 24;
   localparam int          LK_RXRST_BIT    = 23;
   localparam int          LK_XGAP_LSB     = 11;
   localparam int          LK_TGAP_LSB     = 0;
   localparam int          WD_CNT_LSB      = 16;
   localparam int          WD_TMO_LSB      = 0;
   localparam int          GAP_W           = 11;
   localparam int          FREQ_W          = 7;
   localparam int          SYS_CNT_W       = 20;
   localparam int          TILE_CNT_W      = 8;
   localparam int          WD_DIV_W        = 17;

   // ======================================================================
   // reset values and limits
   // ======================================================================
   localparam logic [6:0]  OSC_MHZ_RST     = 7'h19;
   localparam logic [31:0] OSC_MHZ_MIN     = 32'h0000_0005;
   localparam logic [31:0] OSC_MHZ_MAX     = 32'h0000_0064;
   localparam logic [10:0] GAP_RST         = 11'h001;
   localparam logic [15:0] WD_TMO_RST      = 16'h03e8;
   localparam logic [31:0] WD_KEY_OFF      = 32'h0d15ab1e;
   localparam logic [31:0] WD_KEY_ON       = 32'h0000_0000;
   localparam logic [1:0]  MODE_RST        = 2'h0;

   // ======================================================================
   // timing: the watchdog tick is 1 ms, the sleep clock tick 1 us
   // ======================================================================
   localparam int          WD_TICK_US      = 1000;
   localparam int          SYS_RST_OSC_CYC = 524288;

   // ======================================================================
   // carriers
   // ======================================================================
   typedef struct packed {
      logic        valid;     // request present this cycle
      logic        write;     // 1 write, 0 read
      logic        want_rsp;  // write asks for an answer
      logic [7:0]  idx;       // register index
      logic [31:0] wdata;     // write data
   } nrw_req_t;

   typedef struct packed {
      logic        valid;     // answer present this cycle
      logic        ack;       // 1 ack, 0 nack
      logic [31:0] rdata;     // read data
   } nrw_rsp_t;

   typedef struct packed {
      logic rx_overflow;      // receive buffer overflowed (pulse)
      logic rx_bad_token;     // illegal token encoding (pulse)
      logic credit_issued;    // credit given to the far end
      logic credit_held;      // credit held for transmit
   } nrw_lnk_stat_t;

   typedef struct packed {
      logic              greeting;    // send link_greeting_token (pulse)
      logic              credit_clr;  // drop local transmit credit (pulse)
      logic              rx_reset;    // restart receiver framing (pulse)
      logic [GAP_W-1:0]  xfer_gap;    // clocks between transitions
      logic [GAP_W-1:0]  token_gap;   // clocks between tokens
   } nrw_lnk_ctrl_t;

   typedef struct packed {
      logic                  ext_s1;
      logic                  ext_s2;
      logic                  bo_s1;
      logic                  bo_s2;
      logic                  sys_act;
      logic [SYS_CNT_W-1:0]  sys_cnt;
      logic                  tile_act;
      logic [TILE_CNT_W-1:0] tile_cnt;
      logic [1:0]            mode_pins;
      logic                  mode_tri;
      logic [FREQ_W-1:0]     osc_mhz;
      logic                  lnk_err;
      nrw_lnk_ctrl_t         lnk;
      logic [15:0]           wd_tmo;
      logic [15:0]           wd_cnt;
      logic [31:0]           wd_key;
      logic [WD_DIV_W-1:0]   wd_div;
      logic                  wd_exp;
      logic [FREQ_W-1:0]     us_div;
      logic                  rtc_tick;
      nrw_rsp_t              rsp;
   } nrw_state_t;

endpackage : nrw_pkg

// ---- nrw_regs.sv ----
`timescale 1ns/1ps

module nrw_regs
   import nrw_pkg::*;
#(
   parameter int SYS_RST_CYCLES  = nrw_pkg::SYS_RST_OSC_CYC,
   parameter int TILE_RST_CYCLES = 16
)
(
   input  wire logic                   clk_i,              // oscillator clock
   input  wire logic                   rst_i,              // async reset, high
   input  wire nrw_pkg::nrw_req_t      req_i,              // config request
   output nrw_pkg::nrw_rsp_t           rsp_o,              // config answer
   input  wire logic                   ext_rst_n_i,        // reset pin, async
   input  wire logic                   brownout_i,         // any supply low, async
   input  wire logic                   sleep_seq_i,        // sleep sequence pulse
   input  wire logic                   clk_src_chg_i,      // clock source change
   input  wire logic                   active_power_state_i, // active_power_state state
   input  wire nrw_pkg::nrw_lnk_stat_t lnk_stat_i,         // link engine status
   output nrw_pkg::nrw_lnk_ctrl_t      lnk_ctrl_o,         // link engine control
   output logic [1:0]                  mode_pins_o,        // mode pin values
   output logic                        mode_pins_oe_o,     // mode pin drive
   output logic                        sys_rst_o,          // system reset
   output logic                        tile_rst_o,         // tile reset
   output logic                        rtc_tick_o          // 1 us sleep clock tick
);
   import nrw_pkg::*;

   // ======================================================================
   // local constants
   // ======================================================================
   localparam logic [SYS_CNT_W-1:0]  SYS_LAST  = SYS_CNT_W'(SYS_RST_CYCLES - 1);
   localparam logic [TILE_CNT_W-1:0] TILE_LAST = TILE_CNT_W'(TILE_RST_CYCLES - 1);

   // ======================================================================
   // helpers
   // ======================================================================
   // value is a 16-bit word with its ones complement above it
   function automatic logic nrw_cpl_ok(input logic [31:0] w);
      nrw_cpl_ok = (w[31:16] == ~w[15:0]);
   endfunction : nrw_cpl_ok

   // oscillator megahertz times microseconds per watchdog tick
   function automatic logic [WD_DIV_W-1:0] nrw_div_ms(input logic [FREQ_W-1:0] mhz);
      nrw_div_ms = WD_DIV_W'(mhz * WD_TICK_US);
   endfunction : nrw_div_ms

   // state in the reset condition; power-on starts a full system reset
   function automatic nrw_state_t nrw_defaults();
      nrw_state_t d;
      d                = '0;
      d.sys_act        = 1'b1;
      d.osc_mhz        = OSC_MHZ_RST;
      d.mode_pins      = MODE_RST;
      d.lnk.xfer_gap   = GAP_RST;
      d.lnk.token_gap  = GAP_RST;
      d.wd_tmo         = WD_TMO_RST;
      d.wd_key         = WD_KEY_OFF;
      nrw_defaults     = d;
   endfunction : nrw_defaults

   localparam nrw_state_t ST_RESET = nrw_defaults();

   nrw_state_t s_ff;
   nrw_state_t nxt_s;

   // ======================================================================
   // next state
   // ======================================================================
   // all decisions in one place; registers below take nxt_s each edge
   always_comb
   begin
      logic        rd;
      logic        wr;
      logic        sw_sys;
      logic        sw_tile;
      logic        sys_src;
      logic        tile_src;
      logic        wd_tick;
      logic        wd_en;
      logic        rd_link;
      logic [31:0] rdat;
      nxt_s    = s_ff;
      rd       = 1'b0;
      wr       = 1'b0;
      sw_sys   = 1'b0;
      sw_tile  = 1'b0;
      sys_src  = 1'b0;
      tile_src = 1'b0;
      wd_tick  = 1'b0;
      wd_en    = 1'b0;
      rd_link  = 1'b0;
      rdat     = '0;

      // pin synchronisers: first stage feeds only the second
      nxt_s.ext_s1 = ~ext_rst_n_i;
      nxt_s.ext_s2 = s_ff.ext_s1;
      nxt_s.bo_s1  = brownout_i;
      nxt_s.bo_s2  = s_ff.bo_s1;

      // pulse outputs default low
      nxt_s.lnk.greeting   = 1'b0;
      nxt_s.lnk.credit_clr = 1'b0;
      nxt_s.lnk.rx_reset   = 1'b0;
      nxt_s.rsp            = '0;
      nxt_s.wd_exp         = 1'b0;
      nxt_s.rtc_tick       = 1'b0;

      // requests are dropped while the system reset holds the registers
      if (!s_ff.sys_act)
      begin
         rd = req_i.valid & ~req_i.write;
         wr = req_i.valid & req_i.write;
      end

      // ---------------- register reads ----------------
      case (req_i.idx)
         IDX_RST_MODE:
         begin
            rdat[RM_TRI_BIT]                 = s_ff.mode_tri;
            rdat[RM_MODE_LSB +: 2]           = s_ff.mode_pins;
         end
         IDX_OSC_FREQ:
         begin
            rdat[FREQ_W-1:0]                 = s_ff.osc_mhz;
         end
         IDX_LINK_CTRL:
         begin
            rd_link                          = rd;
            rdat[LK_ERR_BIT]                 = s_ff.lnk_err;
            rdat[LK_ERR_BIT-1]               = lnk_stat_i.credit_issued;
            rdat[LK_ERR_BIT-2]               = lnk_stat_i.credit_held;
            rdat[LK_XGAP_LSB +: GAP_W]       = s_ff.lnk.xfer_gap;
            rdat[LK_TGAP_LSB +: GAP_W]       = s_ff.lnk.token_gap;
         end
         IDX_WDOG_CTRL:
         begin
            rdat[WD_CNT_LSB +: 16]           = s_ff.wd_cnt;
            rdat[WD_TMO_LSB +: 16]           = s_ff.wd_tmo;
         end
         IDX_WDOG_KEY:
         begin
            rdat                             = s_ff.wd_key;
         end
         default:
         begin
            rdat                             = '0;
         end
      endcase

      // reads always answer; unmapped indices answer nack with zero data
      if (rd)
      begin
         nxt_s.rsp.valid = 1'b1;
         nxt_s.rsp.rdata = rdat;
         nxt_s.rsp.ack   = (req_i.idx == IDX_RST_MODE) || (req_i.idx == IDX_OSC_FREQ) ||
                           (req_i.idx == IDX_LINK_CTRL) || (req_i.idx == IDX_WDOG_CTRL) ||
                           (req_i.idx == IDX_WDOG_KEY);
      end

      // error flag: event beats a clearing read in the same cycle
      nxt_s.lnk_err = (s_ff.lnk_err & ~rd_link) |
                      lnk_stat_i.rx_overflow | lnk_stat_i.rx_bad_token;

      // ---------------- register writes ----------------
      if (wr)
      begin
         nxt_s.rsp.valid = req_i.want_rsp;
         nxt_s.rsp.ack   = 1'b1;
         case (req_i.idx)
            IDX_RST_MODE:
            begin
               nxt_s.mode_pins = req_i.wdata[RM_MODE_LSB +: 2];
               nxt_s.mode_tri  = req_i.wdata[RM_TRI_BIT];
               sw_tile         = req_i.wdata[RM_TILE_BIT];
               sw_sys          = req_i.wdata[RM_SYS_BIT];
               // no answer when a reset bit is set
               if (sw_sys | sw_tile)
               begin
                  nxt_s.rsp.valid = 1'b0;
               end
            end
            IDX_OSC_FREQ:
            begin
               // range check, ignore and nack outside 5..100
               if ((req_i.wdata >= OSC_MHZ_MIN) && (req_i.wdata <= OSC_MHZ_MAX))
               begin
                  nxt_s.osc_mhz = req_i.wdata[FREQ_W-1:0];
               end
               else
               begin
                  nxt_s.rsp.ack = 1'b0;
               end
            end
            IDX_LINK_CTRL:
            begin
               nxt_s.lnk.xfer_gap   = req_i.wdata[LK_XGAP_LSB +: GAP_W];
               nxt_s.lnk.token_gap  = req_i.wdata[LK_TGAP_LSB +: GAP_W];
               nxt_s.lnk.greeting   = req_i.wdata[LK_GREET_BIT];
               nxt_s.lnk.credit_clr = req_i.wdata[LK_GREET_BIT];
               nxt_s.lnk.rx_reset   = req_i.wdata[LK_RXRST_BIT];
            end
            IDX_WDOG_CTRL:
            begin
               if (nrw_cpl_ok(req_i.wdata))
               begin
                  nxt_s.wd_tmo = req_i.wdata[WD_TMO_LSB +: 16];
                  nxt_s.wd_cnt = req_i.wdata[WD_TMO_LSB +: 16];
               end
               else
               begin
                  nxt_s.rsp.ack = 1'b0;
               end
            end
            IDX_WDOG_KEY:
            begin
               nxt_s.wd_key = req_i.wdata;
            end
            default:
            begin
               nxt_s.rsp.ack = 1'b0;
            end
         endcase
      end

      // ======================================================================
      // watchdog
      // ======================================================================
      // only a stored zero enables; any other key value leaves it stopped
      wd_en = (s_ff.wd_key == WD_KEY_ON);

      // 1 ms tick from the programmed megahertz
      // divider frozen outside the active power state
      if (active_power_state_i)
      begin
         if (s_ff.wd_div >= nrw_div_ms(s_ff.osc_mhz) - WD_DIV_W'(1))
         begin
            nxt_s.wd_div = '0;
            wd_tick      = 1'b1;
         end
         else
         begin
            nxt_s.wd_div = s_ff.wd_div + WD_DIV_W'(1);
         end
      end

      // disable key clears the count, zero enables with a fresh count
      if (wr && (req_i.idx == IDX_WDOG_KEY))
      begin
         if (req_i.wdata == WD_KEY_ON)
         begin
            nxt_s.wd_cnt = s_ff.wd_tmo;
         end
         else
         begin
            nxt_s.wd_cnt = '0;
            nxt_s.wd_div = '0;
         end
      end
      else if (!(wr && (req_i.idx == IDX_WDOG_CTRL) && nrw_cpl_ok(req_i.wdata)))
      begin
         if (wd_en && wd_tick)
         begin
            if (s_ff.wd_cnt <= 16'h0001)
            begin
               // expiry requests a reset and reloads
               nxt_s.wd_exp = 1'b1;
               nxt_s.wd_cnt = s_ff.wd_tmo;
            end
            else
            begin
               nxt_s.wd_cnt = s_ff.wd_cnt - 16'h0001;
            end
         end
      end

      // ======================================================================
      // sleep-mode clock tick
      // ======================================================================
      // 1 us tick follows the programmed frequency
      if (s_ff.us_div >= s_ff.osc_mhz - FREQ_W'(1))
      begin
         nxt_s.us_div   = '0;
         nxt_s.rtc_tick = 1'b1;
      end
      else
      begin
         nxt_s.us_div = s_ff.us_div + FREQ_W'(1);
      end

      // ======================================================================
      // reset generation
      // ======================================================================
      // system sources: pin, brown-out, watchdog, software
      sys_src = s_ff.ext_s2 | s_ff.bo_s2 | s_ff.wd_exp | sw_sys;

      // every source restarts the duration count
      // release only after the full oscillator-cycle count
      if (sys_src)
      begin
         nxt_s.sys_act = 1'b1;
         nxt_s.sys_cnt = '0;
      end
      else if (s_ff.sys_act)
      begin
         if (s_ff.sys_cnt == SYS_LAST)
         begin
            nxt_s.sys_act = 1'b0;
         end
         else
         begin
            nxt_s.sys_cnt = s_ff.sys_cnt + SYS_CNT_W'(1);
         end
      end

      // tile sources: sleep sequence, clock change, software
      tile_src = sleep_seq_i | clk_src_chg_i | sw_tile;
      if (tile_src)
      begin
         nxt_s.tile_act = 1'b1;
         nxt_s.tile_cnt = '0;
      end
      else if (s_ff.tile_act)
      begin
         if (s_ff.tile_cnt == TILE_LAST)
         begin
            nxt_s.tile_act = 1'b0;
         end
         else
         begin
            nxt_s.tile_cnt = s_ff.tile_cnt + TILE_CNT_W'(1);
         end
      end

      // system reset reinitialises the configuration registers
      if (s_ff.sys_act)
      begin
         nxt_s.mode_pins = ST_RESET.mode_pins;
         nxt_s.mode_tri  = ST_RESET.mode_tri;
         nxt_s.osc_mhz   = ST_RESET.osc_mhz;
         nxt_s.lnk       = ST_RESET.lnk;
         nxt_s.lnk_err   = ST_RESET.lnk_err;
         nxt_s.wd_tmo    = ST_RESET.wd_tmo;
         nxt_s.wd_cnt    = ST_RESET.wd_cnt;
         nxt_s.wd_key    = ST_RESET.wd_key;
         nxt_s.wd_div    = ST_RESET.wd_div;
      end
   end

   // ======================================================================
   // state register
   // ======================================================================
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_ff <= ST_RESET;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ======================================================================
   // outputs, all from flip-flops
   // ======================================================================
   assign rsp_o          = s_ff.rsp;
   assign lnk_ctrl_o     = s_ff.lnk;
   assign mode_pins_o    = s_ff.mode_pins;
   assign mode_pins_oe_o = ~s_ff.mode_tri;
   assign sys_rst_o      = s_ff.sys_act;
   // tiles are inside the system, so a system reset covers them too
   assign tile_rst_o     = s_ff.tile_act | s_ff.sys_act;
   assign rtc_tick_o     = s_ff.rtc_tick;

endmodule : nrw_regs

// ---- nrw_regs_properties.sv ----
`timescale 1ns/1ps
// ==================================================
// port checker for the node register block
// ==================================================
module nrw_regs_properties
   import nrw_pkg::*;
#(
   parameter int SYS_RST_CYCLES  = 64,
   parameter int TILE_RST_CYCLES = 4
)
(
   input wire logic                   clk_i,          // clock
   input wire logic                   rst_i,          // reset
   input wire nrw_pkg::nrw_req_t      req_i,          // request
   input wire nrw_pkg::nrw_rsp_t      rsp_o,          // answer
   input wire nrw_pkg::nrw_lnk_ctrl_t lnk_ctrl_o,     // link control
   input wire logic [1:0]             mode_pins_o,    // mode pins
   input wire logic                   mode_pins_oe_o, // pin drive
   input wire logic                   sys_rst_o,      // system reset
   input wire logic                   tile_rst_o      // tile reset
);
   // writes the block takes, only outside system reset
   wire logic  wr  = req_i.valid && req_i.write && !sys_rst_o;
   wire logic  w50 = wr && req_i.idx == IDX_RST_MODE;
   wire logic  w80 = wr && req_i.idx == IDX_LINK_CTRL;
   wire logic  wrs = wr && req_i.want_rsp;
   wire logic  rng = req_i.wdata >= OSC_MHZ_MIN && req_i.wdata <= OSC_MHZ_MAX;
   wire logic  par = req_i.wdata[31:16] == ~req_i.wdata[15:0];
   int unsigned hi_ff;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // length of the current system reset, repetition would be too long
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         hi_ff <= 0;
      else
         hi_ff <= sys_rst_o ? hi_ff + 1 : 0;
   sequence s_greet;
      lnk_ctrl_o.greeting && lnk_ctrl_o.credit_clr ##1 !lnk_ctrl_o.greeting;
   endsequence
   a_rst_len: assert property ($fell(sys_rst_o) |-> hi_ff >= SYS_RST_CYCLES - 1)
      else $error("system reset too short");
   a_tile_sw: assert property (w50 && req_i.wdata[1] |-> ##[1:2] tile_rst_o)
      else $error("tile reset not started");
   a_sys_sw: assert property (w50 && req_i.wdata[0] |-> ##[1:2] sys_rst_o)
      else $error("system reset not started");
   a_rst_silent: assert property (w50 && req_i.wdata[1:0] != 2'h0 |=> !rsp_o.valid)
      else $error("reset write answered");
   a_mode_pins: assert property (w50 && req_i.wdata[1:0] == 2'h0 |=>
      {mode_pins_o, mode_pins_oe_o} == {$past(req_i.wdata[17:16]), !$past(req_i.wdata[24])})
      else $error("mode pins wrong");
   a_freq_ack: assert property (wrs && req_i.idx == IDX_OSC_FREQ |=>
      rsp_o.valid && rsp_o.ack == $past(rng)) else $error("frequency answer wrong");
   a_greet_pulse: assert property (w80 && req_i.wdata[24] |=> s_greet)
      else $error("greeting pulse wrong");
   a_rx_reset: assert property (w80 && req_i.wdata[23] |=> lnk_ctrl_o.rx_reset)
      else $error("receiver reset missing");
   a_wdog_pair: assert property (wrs && req_i.idx == IDX_WDOG_CTRL |=>
      rsp_o.valid && rsp_o.ack == $past(par)) else $error("watchdog answer wrong");
   a_tile_hold: assert property ($rose(tile_rst_o) |-> tile_rst_o[*4])
      else $error("tile reset too short");
endmodule : nrw_regs_properties
bind nrw_regs nrw_regs_properties #(
   .SYS_RST_CYCLES(SYS_RST_CYCLES), .TILE_RST_CYCLES(TILE_RST_CYCLES)
) u_nrw_regs_properties (
   .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o), .lnk_ctrl_o(lnk_ctrl_o),
   .mode_pins_o(mode_pins_o), .mode_pins_oe_o(mode_pins_oe_o), .sys_rst_o(sys_rst_o),
   .tile_rst_o(tile_rst_o));

// ---- nrw_far_end.sv ----
`timescale 1ns/1ps
// ==================================================
// remote link endpoint model
// ==================================================
module nrw_far_end
   import nrw_pkg::*;
(
   input  wire logic                   clk_i,  // clock
   input  wire logic                   rst_i,  // reset
   input  wire logic [1:0]             err_i,  // error kinds to raise
   input  wire logic [3:0]             lat_i,  // credit return delay
   input  wire nrw_pkg::nrw_lnk_ctrl_t ctrl_i, // from the block
   output nrw_pkg::nrw_lnk_stat_t      stat_o  // to the block
);
   logic [3:0] dly_ff;
   logic       held_ff;
   logic       iss_ff;
   // greeting answered with credit after a delay
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         {dly_ff, held_ff, iss_ff} <= 6'h0;
      else if (ctrl_i.greeting)
         {dly_ff, held_ff, iss_ff} <= {lat_i, 2'h1};
      else if (dly_ff != 4'h0)
         {dly_ff, held_ff} <= {dly_ff - 4'h1, dly_ff == 4'h1};
   // credit levels plus error pulses
   assign stat_o = {err_i, iss_ff, held_ff};
endmodule : nrw_far_end

// ---- tb_nrw_regs.sv ----
`timescale 1ns/1ps
// ==================================================
// bench for the node register block
// ==================================================
module tb_nrw_regs;
   import nrw_pkg::*;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic        k;
      logic [31:0] q;
   } nrw_row_t;
   logic          clk_i, rst_i, ext_n, bo, slp, csc, act, got, oe, sys, tile, rtc;
   logic [1:0]    err, pins;
   logic [3:0]    lat;
   int            failures, n_checks, n, n_tk;
   nrw_req_t      req;
   nrw_rsp_t      rsp;
   nrw_lnk_stat_t stat;
   nrw_lnk_ctrl_t ctrl;
   // plain accesses: kind, index, data, ack, read data
   nrw_row_t      rows [12] = '{
      '{1'h0, 8'h51, 32'h0, 1'h1, 32'h19},
      '{1'h0, 8'h80, 32'h0, 1'h1, 32'h801},
      '{1'h0, 8'hd6, 32'h0, 1'h1, 32'h3e8},
      '{1'h0, 8'hd7, 32'h0, 1'h1, 32'hd15ab1e},
      '{1'h0, 8'h50, 32'h0, 1'h1, 32'h0},
      '{1'h0, 8'h33, 32'h0, 1'h0, 32'h0},        // unmapped
      '{1'h1, 8'h51, 32'h4, 1'h0, 32'h0},
      '{1'h1, 8'h51, 32'h65, 1'h0, 32'h0},
      '{1'h1, 8'h51, 32'h105, 1'h0, 32'h0},
      '{1'h1, 8'h51, 32'h5, 1'h1, 32'h0},
      '{1'h1, 8'h80, 32'h1807, 1'h1, 32'h0},
      '{1'h1, 8'h50, 32'h1030000, 1'h1, 32'h0}};
   nrw_regs #(.SYS_RST_CYCLES(64), .TILE_RST_CYCLES(4)) u_nrw_regs (
      .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp), .ext_rst_n_i(ext_n),
      .brownout_i(bo), .sleep_seq_i(slp), .clk_src_chg_i(csc), .active_power_state_i(act),
      .lnk_stat_i(stat), .lnk_ctrl_o(ctrl), .mode_pins_o(pins), .mode_pins_oe_o(oe),
      .sys_rst_o(sys), .tile_rst_o(tile), .rtc_tick_o(rtc));
   nrw_far_end u_nrw_far_end (
      .clk_i(clk_i), .rst_i(rst_i), .err_i(err), .lat_i(lat), .ctrl_i(ctrl), .stat_o(stat));
   always @(posedge clk_i) n_tk += rtc;
   initial
   begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // request held one cycle, answer awaited for two cycles
   task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_i);
      req = '{1'h1, w, 1'h1, a, d};
      @(negedge clk_i);
      req.valid = 1'h0;
      for (int k = 0; k < 2 && rsp.valid !== 1'h1; k++)
         @(negedge clk_i);
      got = rsp.valid === 1'h1;
   endtask : op
   task automatic ask(input nrw_row_t r);
      op(r.w, r.a, r.d);
      chk({31'h0, got}, 32'h1, "answer");
      chk({31'h0, rsp.ack}, {31'h0, r.k}, "ack");
      if (!r.w)
         chk(rsp.rdata, r.q, "rdata");
   endtask : ask
   // bounded wait for a reset output level; running out ends the run
   task automatic wait_for(input logic t, input logic lvl, input int lim);
      n = 0;
      while ((t ? tile : sys) !== lvl)
      begin
         @(negedge clk_i);
         n++;
         if (n > lim)
         begin
            failures++;
            end_sim();
         end
      end
   endtask : wait_for
   initial
   begin
      rst_i = 1'h1;
      ext_n = 1'h1;
      {bo, slp, csc, act, err} = 6'h0;
      lat = 4'h5;
      req = '0;
      repeat (6) @(negedge clk_i);
      rst_i = 1'h0;
      wait_for(1'h0, 1'h0, 80);
      chk({31'h0, n inside {[63:65]}}, 32'h1, "reset length");
      foreach (rows[i]) ask(rows[i]);
      $display("table done");
      for (int e = 1; e < 3; e++)
      begin
         err = e[1:0];
         @(negedge clk_i);
         err = 2'h0;
         ask('{1'h0, 8'h80, 32'h0, 1'h1, 32'h0800_1807});
         ask('{1'h0, 8'h80, 32'h0, 1'h1, 32'h0000_1807});
      end
      ask('{1'h1, 8'h80, 32'h0100_1807, 1'h1, 32'h0});
      repeat (8) @(negedge clk_i);
      chk({ctrl.xfer_gap, ctrl.token_gap}, 32'h1807, "gaps");
      ask('{1'h0, 8'h80, 32'h0, 1'h1, 32'h0600_1807});
      ask('{1'h1, 8'h80, 32'h0080_1807, 1'h1, 32'h0});
      ask('{1'h1, 8'h50, 32'h0002_0000, 1'h1, 32'h0});
      chk({29'h0, pins, oe}, 32'h5, "pins");
      $display("link done");
      for (int j = 0; j < 2; j++)
      begin
         {slp, csc} = j[0] ? 2'h1 : 2'h2;
         @(negedge clk_i);
         {slp, csc} = 2'h0;
         wait_for(1'h1, 1'h1, 4);
         chk({31'h0, sys}, 32'h0, "sys quiet");
         wait_for(1'h1, 1'h0, 20);
      end
      op(1'h1, 8'h50, 32'h2);
      chk({30'h0, got, sys, tile}, 32'h1, "tile write");
      wait_for(1'h1, 1'h0, 20);
      ask('{1'h1, 8'hd6, 32'hfffd_0002, 1'h1, 32'h0});
      ask('{1'h1, 8'hd6, 32'hfffd_0003, 1'h0, 32'h0});
      ask('{1'h1, 8'hd7, 32'h0, 1'h1, 32'h0});
      repeat (5000) @(negedge clk_i);
      ask('{1'h0, 8'hd6, 32'h0, 1'h1, 32'h0002_0002});
      act = 1'h1;
      n = n_tk;
      repeat (7000) @(negedge clk_i);
      chk(n_tk - n, 1400, "tick");
      ask('{1'h0, 8'hd6, 32'h0, 1'h1, 32'h0001_0002});
      ask('{1'h1, 8'hd6, 32'hfffd_0002, 1'h1, 32'h0});
      ask('{1'h0, 8'hd6, 32'h0, 1'h1, 32'h0002_0002});
      wait_for(1'h0, 1'h1, 10100);
      chk({31'h0, n >= 5000}, 32'h1, "expiry time");
      wait_for(1'h0, 1'h0, 90);
      ask('{1'h0, 8'hd7, 32'h0, 1'h1, 32'h0d15_ab1e});
      ask('{1'h0, 8'hd6, 32'h0, 1'h1, 32'h0000_03e8});
      $display("watchdog done");
      for (int j = 0; j < 2; j++)
      begin
         {ext_n, bo} = j[0] ? 2'h3 : 2'h0;
         wait_for(1'h0, 1'h1, 8);
         repeat (30) @(negedge clk_i);
         {ext_n, bo} = 2'h2;
         wait_for(1'h0, 1'h0, 90);
         chk({31'h0, n >= 64}, 32'h1, "restart");
      end
      ask('{1'h1, 8'h51, 32'h64, 1'h1, 32'h0});
      op(1'h1, 8'h50, 32'h1);
      chk({30'h0, got, sys}, 32'h1, "sys write");
      wait_for(1'h0, 1'h0, 90);
      ask('{1'h0, 8'h51, 32'h0, 1'h1, 32'h19});
      $display("resets done");
      end_sim();
   end
endmodule : tb_nrw_regs
